// ### design/data_paging_and_eeprom_ctrl.v
// Purpose: Data-space paging, ROM window and nonvolatile page write control
// Assumes: CPU data-space strobes synchronous to sys_clk_i; memories external
// Notes:
`timescale 1ns/10ps
`include "paging_consts.vh"

module data_paging_and_eeprom_ctrl #(
    parameter PROG_CYCLES = `PROG_CYCLES_DEF
) (
    input  wire        sys_clk_i,
    input  wire        nrst_i,
    // CPU data-space access
    input  wire [7:0]  cpu_addr_i,
    input  wire [7:0]  cpu_wdata_i,
    input  wire        cpu_wr_i,
    input  wire        cpu_rd_i,
    input  wire        stop_i,
    output reg  [7:0]  cpu_rdata_o,
    output wire        cpu_rdata_valid_o,
    // Program memory read port for the window
    output reg  [11:0] rom_addr_o,
    output wire        rom_rd_o,
    input  wire [7:0]  rom_data_i,
    // Extra RAM page port
    output reg  [5:0]  ram2_addr_o,
    output reg  [7:0]  ram2_wdata_o,
    output wire        ram2_wr_o,
    output wire        ram2_rd_o,
    input  wire [7:0]  ram2_rdata_i,
    // Nonvolatile page port
    output reg  [5:0]  nv_addr_o,
    output wire        nv_rd_o,
    input  wire [7:0]  nv_rdata_i,
    output reg         nv_prog_o,
    output reg  [5:0]  nv_prog_addr_o,
    output reg  [63:0] nv_prog_data_o,
    output reg  [7:0]  nv_prog_mask_o,
    output wire        nv_power_down_o
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    localparam [15:0] PROG_LEN = PROG_CYCLES[15:0];

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_BYTE = 3'b010;
    localparam [2:0] ST_ROW  = 3'b100;

    reg  [5:0]  window_upper_bits;
    reg  [7:0]  bank_select_reg;
    reg         standby_bit;
    reg         row_start_bit;
    reg         row_mode_bit;
    reg         write_enable_bit;
    reg         stopped;
    reg  [2:0]  state;
    reg  [15:0] prog_cnt;
    reg  [2:0]  row_addr;
    reg         row_addr_valid;
    reg  [2:0]  rd_src;

    wire program_busy_flag = (state != ST_IDLE);
    wire in_paged   = (cpu_addr_i[7:6] == `PAGED_TOP);
    wire in_window  = (cpu_addr_i[7:6] == `WINDOW_TOP);
    wire ram2_sel   = bank_select_reg[`BANK_RAM_PAGE2_BIT];
    wire nv_sel     = bank_select_reg[`BANK_NV_PAGE0_BIT];
    wire nv_live    = nv_sel && !standby_bit && !stopped;
    wire nv_access  = in_paged && nv_live && !program_busy_flag;
    wire row_match  = !row_addr_valid || (row_addr == cpu_addr_i[5:3]);
    wire ctl_wr     = cpu_wr_i && (cpu_addr_i == `ADDR_NV_CONTROL);
    wire nv_wr      = cpu_wr_i && nv_access && write_enable_bit;
    wire byte_go    = nv_wr && !row_mode_bit;
    wire row_load   = nv_wr && row_mode_bit && row_match;
    wire ctl_take   = ctl_wr && !program_busy_flag;
    wire row_enter  = ctl_take && cpu_wdata_i[`CTL_ROW_MODE_BIT] && !row_mode_bit;
    wire row_go     = ctl_take && cpu_wdata_i[`CTL_ROW_START_BIT]
                      && cpu_wdata_i[`CTL_WR_ENABLE_BIT]
                      && cpu_wdata_i[`CTL_ROW_MODE_BIT] && row_mode_bit;
    wire [63:0] row_data;
    wire [7:0]  row_used;

    // ----------------------------------------------------------------
    // Row latches
    // ----------------------------------------------------------------
    row_latch_bank #(
        .ROW_BYTES (`ROW_BYTES)
    ) u_rows (
        .sys_clk_i   (sys_clk_i),
        .nrst_i      (nrst_i),
        .clear_i     (row_enter),
        .load_i      (row_load),
        .load_idx_i  (cpu_addr_i[2:0]),
        .load_data_i (cpu_wdata_i),
        .row_data_o  (row_data),
        .row_used_o  (row_used)
    );

    // ----------------------------------------------------------------
    // Window and bank registers (no reset: contents undefined)
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        if (cpu_wr_i && (cpu_addr_i == `ADDR_ROM_WINDOW)) begin
            window_upper_bits <= cpu_wdata_i[`WINDOW_BITS-1:0];
        end
        if (cpu_wr_i && (cpu_addr_i == `ADDR_BANK_SELECT)) begin
            bank_select_reg <= cpu_wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // Control register and programming sequencer
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            standby_bit      <= 1'b0;
            row_start_bit    <= 1'b0;
            row_mode_bit     <= 1'b0;
            write_enable_bit <= 1'b0;
            stopped          <= 1'b0;
            state            <= ST_IDLE;
            prog_cnt         <= 16'h0000;
            row_addr         <= 3'h0;
            row_addr_valid   <= 1'b0;
            nv_prog_o        <= 1'b0;
            nv_prog_addr_o   <= 6'h00;
            nv_prog_data_o   <= 64'h0000000000000000;
            nv_prog_mask_o   <= 8'h00;
        end else begin
            nv_prog_o <= 1'b0;
            if (stop_i) begin
                stopped <= 1'b1;
            end else if (cpu_rd_i || cpu_wr_i) begin
                stopped <= 1'b0;
            end
            if (ctl_take) begin
                standby_bit      <= cpu_wdata_i[`CTL_STANDBY_BIT];
                write_enable_bit <= cpu_wdata_i[`CTL_WR_ENABLE_BIT];
                row_mode_bit     <= cpu_wdata_i[`CTL_ROW_MODE_BIT];
                row_start_bit    <= row_go;
                if (!cpu_wdata_i[`CTL_ROW_MODE_BIT] || row_enter) begin
                    row_addr_valid <= 1'b0;
                end
            end
            if (row_load) begin
                row_addr       <= cpu_addr_i[5:3];
                row_addr_valid <= 1'b1;
            end
            case (state)
                ST_IDLE: begin
                    if (byte_go) begin
                        state          <= ST_BYTE;
                        prog_cnt       <= PROG_LEN;
                        nv_prog_o      <= 1'b1;
                        nv_prog_addr_o <= cpu_addr_i[5:0];
                        nv_prog_data_o <= {56'h00000000000000, cpu_wdata_i};
                        nv_prog_mask_o <= 8'h01;
                    end else if (row_go) begin
                        state          <= ST_ROW;
                        prog_cnt       <= PROG_LEN;
                        nv_prog_o      <= 1'b1;
                        nv_prog_addr_o <= {row_addr, 3'h0};
                        nv_prog_data_o <= row_data;
                        nv_prog_mask_o <= row_used;
                    end
                end
                ST_BYTE, ST_ROW: begin
                    if (prog_cnt <= 16'h0001) begin
                        state <= ST_IDLE;
                        if (state == ST_ROW) begin
                            row_mode_bit   <= 1'b0;
                            row_start_bit  <= 1'b0;
                            row_addr_valid <= 1'b0;
                        end
                    end else begin
                        prog_cnt <= prog_cnt - 16'h0001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read path and memory ports
    // ----------------------------------------------------------------
    assign rom_rd_o          = cpu_rd_i && in_window;
    assign ram2_rd_o         = cpu_rd_i && in_paged && ram2_sel;
    assign ram2_wr_o         = cpu_wr_i && in_paged && ram2_sel;
    assign nv_rd_o           = cpu_rd_i && nv_access && row_match;
    assign nv_power_down_o   = standby_bit || stopped;
    assign cpu_rdata_valid_o = |rd_src;

    always @* begin
        rom_addr_o   = {window_upper_bits, cpu_addr_i[5:0]};
        ram2_addr_o  = cpu_addr_i[5:0];
        ram2_wdata_o = cpu_wdata_i;
        nv_addr_o    = cpu_addr_i[5:0];
    end

    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_src <= 3'b000;
        end else begin
            rd_src <= {cpu_rd_i && (cpu_addr_i == `ADDR_NV_CONTROL), nv_rd_o | ram2_rd_o, rom_rd_o};
        end
    end

    // Control read shows only the busy flag; write-only bits read as zero
    always @* begin
        cpu_rdata_o = 8'h00;
        if (rd_src[0]) begin
            cpu_rdata_o = rom_data_i;
        end else if (rd_src[1]) begin
            cpu_rdata_o = nv_sel ? nv_rdata_i : ram2_rdata_i;
        end else if (rd_src[2]) begin
            cpu_rdata_o[`CTL_BUSY_BIT] = program_busy_flag;
        end
    end

endmodule

// ### design/paging_consts.vh
// Purpose: Constants for data-space paging and nonvolatile memory control
// Assumes: 8-bit data space addresses, 8-bit data
// Notes:   Definitions only
`ifndef PAGING_CONSTS_VH
`define PAGING_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_ROM_WINDOW     8'hC9
`define ADDR_BANK_SELECT    8'hE8
`define ADDR_NV_CONTROL     8'hEA

// ----------------------------------------------------------------
// Data-space regions
// ----------------------------------------------------------------
`define PAGED_TOP           2'h0
`define WINDOW_TOP          2'h1

// ----------------------------------------------------------------
// Bank select fields
// ----------------------------------------------------------------
`define BANK_RAM_PAGE2_BIT  4
`define BANK_NV_PAGE0_BIT   0
`define BANK_RAM_PAGE2_VAL  8'h10
`define BANK_NV_PAGE0_VAL   8'h01

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define CTL_STANDBY_BIT     6
`define CTL_ROW_START_BIT   3
`define CTL_ROW_MODE_BIT    2
`define CTL_BUSY_BIT        1
`define CTL_WR_ENABLE_BIT   0
`define CTL_RESET_VAL       8'h00

// ----------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------
`define ROW_BYTES           8
`define WINDOW_BITS         6
`define PROG_CYCLES_DEF     1000

`endif

// ### design/row_latch_bank.v
// Purpose: Eight row latches with per-byte written flags for row programming
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Clear has priority over load
`timescale 1ns/10ps
`include "paging_consts.vh"

module row_latch_bank #(
    parameter ROW_BYTES = `ROW_BYTES
) (
    input  wire                   sys_clk_i,
    input  wire                   nrst_i,
    input  wire                   clear_i,
    input  wire                   load_i,
    input  wire [2:0]             load_idx_i,
    input  wire [7:0]             load_data_i,
    output wire [ROW_BYTES*8-1:0] row_data_o,
    output wire [ROW_BYTES-1:0]   row_used_o
);

    genvar g;
    generate
        for (g = 0; g < ROW_BYTES; g = g + 1) begin : g_byte
            localparam [2:0] IDX = g;
            reg [7:0] data;
            reg       used;
            always @(posedge sys_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    data <= 8'h00;
                    used <= 1'b0;
                end else if (clear_i) begin
                    data <= 8'h00;
                    used <= 1'b0;
                end else if (load_i && (load_idx_i == IDX)) begin
                    data <= load_data_i;
                    used <= 1'b1;
                end
            end
            assign row_data_o[g*8 +: 8] = data;
            assign row_used_o[g]        = used;
        end
    endgenerate

endmodule

// ### verification/cpu_model.sv
// Purpose: CPU core model issuing data-space reads and writes
// Assumes: One-cycle strobes launched just after a rising edge
// Notes:   Never reads write-only registers; sets one bank bit at a time
`timescale 1ns/10ps
module cpu_model (
    input  wire       sys_clk_i,
    input  wire [7:0] rdata_i,
    input  wire       valid_i,
    output reg  [7:0] addr_o,
    output reg  [7:0] wdata_o,
    output reg        wr_o,
    output reg        rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Callers keep a RAM image first and one bank bit only
    task wr(input [7:0] a, input [7:0] d);
        @(posedge sys_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge sys_clk_i);
        wr_o <= 1'b0;
    endtask
    // Address held through the answer cycle; no reads of write-only places
    task rd(input [7:0] a, output [7:0] d);
        @(posedge sys_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge sys_clk_i);
        rd_o <= 1'b0;
        #1;
        d = valid_i ? rdata_i : 8'hXX;
    endtask
endmodule

// ### verification/paging_checker.sv
// Purpose: Port-level assertions for the paging and nonvolatile control block
// Assumes: Single clock, async active-low reset; PROG_CYCLES of at least 3
// Notes:   Attached by bind from the testbench top file
`timescale 1ns/10ps
module paging_checker #(
    parameter PROG_CYCLES = 1000
) (
    input wire        sys_clk_i,
    input wire        nrst_i,
    input wire [7:0]  cpu_addr_i,
    input wire [7:0]  cpu_wdata_i,
    input wire        cpu_wr_i,
    input wire        cpu_rd_i,
    input wire        stop_i,
    input wire [7:0]  cpu_rdata_o,
    input wire        cpu_rdata_valid_o,
    input wire [11:0] rom_addr_o,
    input wire        rom_rd_o,
    input wire [7:0]  rom_data_i,
    input wire [5:0]  ram2_addr_o,
    input wire [7:0]  ram2_wdata_o,
    input wire        ram2_wr_o,
    input wire        nv_rd_o,
    input wire        nv_prog_o,
    input wire [5:0]  nv_prog_addr_o,
    input wire [7:0]  nv_prog_mask_o,
    input wire        nv_power_down_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_read_answer: assert property (cpu_rd_i |=> cpu_rdata_valid_o)
        else $error("read not answered");
    chk_valid_cause: assert property (cpu_rdata_valid_o |-> $past(cpu_rd_i))
        else $error("read valid without read");
    chk_window_addr: assert property (rom_rd_o |-> cpu_rd_i && cpu_addr_i[7:6] == 2'h1
        && rom_addr_o[5:0] == cpu_addr_i[5:0]) else $error("window address wrong");
    chk_window_read: assert property (cpu_rd_i && cpu_addr_i[7:6] == 2'h1 |-> rom_rd_o)
        else $error("window read missed");
    chk_window_data: assert property (rom_rd_o |=> cpu_rdata_o == rom_data_i)
        else $error("window data wrong");
    chk_ram2_write: assert property (ram2_wr_o |-> cpu_wr_i && cpu_addr_i < 8'h40
        && ram2_addr_o == cpu_addr_i[5:0] && ram2_wdata_o == cpu_wdata_i) else $error("page write wrong");
    chk_prog_cause: assert property (nv_prog_o |-> $past(cpu_wr_i)
        && ($past(cpu_addr_i) < 8'h40 || $past(cpu_addr_i) == 8'hEA)) else $error("program without write");
    chk_prog_gap: assert property (nv_prog_o |=> !nv_prog_o [*3])
        else $error("program restarted while busy");
    chk_row_base: assert property (nv_prog_o && nv_prog_mask_o != 8'h01 |-> nv_prog_addr_o[2:0] == 3'h0)
        else $error("row base not aligned");
    chk_stop_power: assert property (stop_i |=> nv_power_down_o)
        else $error("stop did not power down");
    chk_standby_read: assert property (nv_power_down_o |-> !nv_rd_o)
        else $error("read while powered down");
endmodule

// ### verification/tb_data_paging_and_eeprom_ctrl.sv
// Purpose: Self-checking bench for paging and nonvolatile control
// Assumes: PROG_CYCLES shortened to 8
// Notes:   Memories modelled here as one-cycle synchronous arrays
`timescale 1ns/10ps
module tb_data_paging_and_eeprom_ctrl;
    reg sys_clk_i = 1'b0;
    reg nrst_i = 1'b0;
    reg stop_i = 1'b0;
    reg [7:0] rom_data_i = 8'h00, ram2_rdata_i = 8'h00, nv_rdata_i = 8'h00, d;
    wire [7:0] cpu_addr_i, cpu_wdata_i, cpu_rdata_o, ram2_wdata_o, nv_prog_mask_o;
    wire cpu_wr_i, cpu_rd_i, cpu_rdata_valid_o, rom_rd_o, ram2_wr_o, ram2_rd_o, nv_rd_o, nv_prog_o, nv_power_down_o;
    wire [11:0] rom_addr_o;
    wire [5:0] ram2_addr_o, nv_addr_o, nv_prog_addr_o;
    wire [63:0] nv_prog_data_o;
    reg [7:0] ram2_mem [0:63];
    reg [7:0] nv_mem [0:63];
    reg [5:0] p_addr;
    reg [7:0] p_mask;
    integer errors = 0, comparisons = 0, progs = 0, i;

    data_paging_and_eeprom_ctrl #(.PROG_CYCLES(8)) dut (.*);
    cpu_model cpu (.sys_clk_i(sys_clk_i), .rdata_i(cpu_rdata_o), .valid_i(cpu_rdata_valid_o),
        .addr_o(cpu_addr_i), .wdata_o(cpu_wdata_i), .wr_o(cpu_wr_i), .rd_o(cpu_rd_i));

    function [7:0] rom_f(input [11:0] a);
        rom_f = a[11:4] ^ {4'h0, a[3:0]};
    endfunction

    initial begin
        for (i = 0; i < 64; i = i + 1) nv_mem[i] = 8'hFF;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // ------------------------------------------------------------
    // Memory models
    // ------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        if (rom_rd_o) rom_data_i <= rom_f(rom_addr_o);
        if (ram2_rd_o) ram2_rdata_i <= ram2_mem[ram2_addr_o];
        if (ram2_wr_o) ram2_mem[ram2_addr_o] <= ram2_wdata_o;
        if (nv_rd_o) nv_rdata_i <= nv_mem[nv_addr_o];
        if (nv_prog_o) begin
            progs <= progs + 1;
            p_addr <= nv_prog_addr_o;
            p_mask <= nv_prog_mask_o;
            for (i = 0; i < 8; i = i + 1)
                if (nv_prog_mask_o[i]) nv_mem[nv_prog_addr_o + i] <= nv_prog_data_o[8*i +: 8];
        end
    end

    task chk(input string name, input [7:0] exp, input [7:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task idle(input integer n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task end_sim;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_window_and_page;
        cpu.wr(8'hC9, 8'hEA);
        cpu.rd(8'h45, d);
        chk("window byte", rom_f(12'hA85), d);
        cpu.wr(8'hE8, 8'h10);
        cpu.wr(8'h05, 8'h77);
        cpu.rd(8'h05, d);
        chk("ram page byte", 8'h77, d);
        $display("window and page done");
    endtask
    task t_byte_mode;
        cpu.wr(8'hE8, 8'h01);
        cpu.wr(8'hEA, 8'h01);
        cpu.wr(8'h12, 8'hC3);
        cpu.rd(8'hEA, d);
        chk("busy status", 8'h02, d);
        cpu.wr(8'hEA, 8'h00);
        cpu.wr(8'h13, 8'h55);
        idle(10);
        chk("byte programs", 8'h01, progs[7:0]);
        chk("byte address", 8'h12, {2'h0, p_addr});
        chk("byte mask", 8'h01, p_mask);
        cpu.wr(8'h14, 8'h66);
        idle(12);
        chk("enable kept", 8'h02, progs[7:0]);
        cpu.rd(8'h12, d);
        chk("nv read", 8'hC3, d);
        $display("byte mode done");
    endtask
    task t_refused;
        cpu.wr(8'hEA, 8'h00);
        cpu.wr(8'h15, 8'h01);
        cpu.wr(8'hEA, 8'h41);
        cpu.wr(8'h16, 8'h02);
        idle(3);
        chk("power down", 8'h01, {7'h0, nv_power_down_o});
        chk("no program", 8'h02, progs[7:0]);
        cpu.wr(8'hEA, 8'h01);
        $display("refusals done");
    endtask
    task t_row;
        cpu.wr(8'hEA, 8'h05);
        cpu.wr(8'h18, 8'h11);
        cpu.wr(8'h1A, 8'h22);
        cpu.wr(8'h1B, 8'h33);
        cpu.wr(8'h20, 8'h44);
        cpu.wr(8'h1A, 8'h2B);
        cpu.wr(8'hEA, 8'h0D);
        idle(12);
        chk("row base", 8'h18, {2'h0, p_addr});
        chk("row mask", 8'h0D, p_mask);
        chk("row byte2", 8'h2B, nv_mem[8'h1A]);
        chk("row untouched", 8'hFF, nv_mem[8'h19]);
        chk("other row", 8'hFF, nv_mem[8'h20]);
        cpu.wr(8'hEA, 8'h09);
        cpu.wr(8'hEA, 8'h05);
        cpu.wr(8'h1C, 8'h99);
        cpu.wr(8'hEA, 8'h01);
        cpu.wr(8'hEA, 8'h09);
        idle(3);
        chk("row programs", 8'h03, progs[7:0]);
        chk("abandoned row", 8'hFF, nv_mem[8'h1C]);
        $display("row mode done");
    endtask
    task t_stop_reset;
        stop_i <= 1'b1;
        idle(1);
        stop_i <= 1'b0;
        #1;
        chk("stop power down", 8'h01, {7'h0, nv_power_down_o});
        cpu.wr(8'hEA, 8'h41);
        nrst_i <= 1'b0;
        idle(2);
        nrst_i <= 1'b1;
        idle(2);
        chk("reset power", 8'h00, {7'h0, nv_power_down_o});
        cpu.rd(8'hEA, d);
        chk("reset control", 8'h00, d);
        $display("stop and reset done");
    endtask

    initial begin
        #8000;
        errors = errors + 1;
        end_sim;
    end
    initial begin
        idle(6);
        nrst_i <= 1'b1;
        t_window_and_page;
        t_byte_mode;
        t_refused;
        t_row;
        t_stop_reset;
        end_sim;
    end
endmodule

bind data_paging_and_eeprom_ctrl paging_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.*);
